// file: hdl/wqc_write_port.sv
`timescale 1ns/10ps
`include "wqc_map.svh"

module wqc_write_port #(
    parameter int DATA_W = `WQC_DATA_W,
    parameter int DEPTH = `WQC_FIFO_DEPTH
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // host write pins
    input wire logic wrClk,
    input wire logic writeEnableN,
    input wire logic writePortSelectN,
    input wire logic [DATA_W-1:0] wrData,
    // rate strap
    input wire logic writeRateSelect,
    // status
    output logic wrFull,
    output logic wrOverflow,
    output logic ddrMode,
    // captured words
    output logic outValid,
    input wire logic outReady,
    output logic [DATA_W-1:0] outData
);

    typedef struct packed {
        wqc_pkg::wqc_ctl_s ctl1;
        wqc_pkg::wqc_ctl_s ctl2;
        wqc_pkg::wqc_ctl_s ctl3;
        logic [DATA_W-1:0] dat1;
        logic [DATA_W-1:0] dat2;
        logic [DATA_W-1:0] dat3;
        logic clkLvl;
        wqc_pkg::wqc_phase_e phase;
        logic [1:0] armCnt;
        wqc_pkg::wqc_rate_e rate;
        logic riseQual;
        logic capValid;
        logic [DATA_W-1:0] capData;
        logic overflow;
    } wqc_top_s;

    logic rstMeta_q;
    logic rstSync_q;
    wqc_top_s q;
    wqc_top_s d;
    logic fifoReady;
    logic clkStable;
    logic riseEdge;
    logic fallEdge;
    logic pinQual;
    logic holdBusy;
    logic newWord;

    ////////////////////////////////////////////////////////////////////////
    // reset release
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // edge detection on the sampled write clock
    assign clkStable = (q.ctl2.wrClk == q.ctl3.wrClk);
    assign riseEdge = clkStable && q.ctl3.wrClk && !q.clkLvl;
    assign fallEdge = clkStable && !q.ctl3.wrClk && q.clkLvl;
    assign pinQual = !q.ctl3.enN && !q.ctl3.selN;
    assign holdBusy = q.capValid && !fifoReady;

    always_comb begin
        d = q;
        newWord = 1'b0;
        d.ctl1 = '{wrClk: wrClk, enN: writeEnableN,
                   selN: writePortSelectN, rate: writeRateSelect};
        d.ctl2 = q.ctl1;
        d.ctl3 = q.ctl2;
        d.dat1 = wrData;
        d.dat2 = q.dat1;
        d.dat3 = q.dat2;
        d.overflow = 1'b0;
        if (clkStable) begin
            d.clkLvl = q.ctl3.wrClk;
        end
        if (q.phase == wqc_pkg::PH_ARM) begin
            if (q.armCnt == `WQC_ARM_CYCLES) begin
                d.rate = wqc_pkg::wqc_rate_e'(q.ctl3.rate);
                d.phase = wqc_pkg::PH_RUN;
            end else begin
                d.armCnt = q.armCnt + 2'h1;
            end
        end else begin
            if (riseEdge) begin
                d.riseQual = pinQual;
                newWord = pinQual;
            end
            if (fallEdge && q.rate == wqc_pkg::RATE_DDR) begin
                newWord = q.riseQual;
            end
        end
        // a word arriving while the hold register is stalled is lost
        if (newWord && holdBusy) begin
            d.overflow = 1'b1;
        end else if (newWord) begin
            d.capValid = 1'b1;
            d.capData = q.dat3;
        end else begin
            d.capValid = holdBusy;
        end
    end

    always_ff @(posedge sys_clk or negedge rstSync_q) begin
        if (!rstSync_q) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // capture buffer
    wqc_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(sys_clk),
        .rstN(rstSync_q),
        .inValid(q.capValid),
        .inReady(fifoReady),
        .inData(q.capData),
        .outValid(outValid),
        .outReady(outReady),
        .outData(outData)
    );

    assign wrFull = holdBusy || !fifoReady;
    assign wrOverflow = q.overflow;
    assign ddrMode = (q.rate == wqc_pkg::RATE_DDR);

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstSync_q);

    edge_only_a: assert property (
        newWord |-> (riseEdge || fallEdge))
        else $error("word taken away from a clock edge");

    rise_write_a: assert property (
        (q.phase == wqc_pkg::PH_RUN && riseEdge && pinQual && !holdBusy)
        |=> (q.capValid && q.capData == $past(q.dat3)))
        else $error("qualified rising edge word not captured");

    no_write_idle_a: assert property (
        (riseEdge && (q.ctl3.enN || q.ctl3.selN)) |=> !$past(newWord))
        else $error("word taken without both strobes low");

    rate_frozen_a: assert property (
        (q.phase == wqc_pkg::PH_RUN) |=> $stable(q.rate))
        else $error("rate changed after reset");

    arm_no_write_a: assert property (
        (q.phase == wqc_pkg::PH_ARM) |-> !newWord)
        else $error("word taken before rate was latched");

    ddr_fall_take_a: assert property (
        (q.phase == wqc_pkg::PH_RUN && q.rate == wqc_pkg::RATE_DDR
         && fallEdge && q.riseQual && !holdBusy)
        |=> (q.capValid && q.capData == $past(q.dat3)))
        else $error("qualified falling edge word not captured");

    sdr_no_fall_a: assert property (
        (q.rate == wqc_pkg::RATE_SDR && fallEdge) |-> !newWord)
        else $error("falling edge word in single rate mode");

    fall_qual_a: assert property (
        (q.phase == wqc_pkg::PH_RUN && q.rate == wqc_pkg::RATE_DDR
         && fallEdge) |-> (newWord == q.riseQual))
        else $error("falling word not qualified by the rising edge");

    rise_qual_keep_a: assert property (
        (q.phase == wqc_pkg::PH_RUN && riseEdge)
        |=> (q.riseQual == $past(pinQual)))
        else $error("rising edge qualifier not kept");

    strap_take_a: assert property (
        (q.phase == wqc_pkg::PH_ARM && q.armCnt == `WQC_ARM_CYCLES)
        |=> (q.phase == wqc_pkg::PH_RUN && q.rate == $past(q.ctl3.rate)))
        else $error("rate strap not taken at end of arming");

    sdr_rise_only_a: assert property (
        (q.rate == wqc_pkg::RATE_SDR && newWord) |-> (riseEdge && pinQual))
        else $error("single rate word not from a qualified rising edge");

    lost_word_a: assert property (
        (newWord && holdBusy) |=> (wrOverflow && q.capValid))
        else $error("word lost while stalled not flagged");

    hold_keep_a: assert property (
        holdBusy |=> (q.capValid && $stable(q.capData)))
        else $error("stalled hold register changed");

endmodule

// file: hdl/wqc_map.svh
`ifndef WQC_MAP_SVH
`define WQC_MAP_SVH

// data word width of the write port
`define WQC_DATA_W 40
// words held in the capture buffer memory; its output register holds one more
`define WQC_FIFO_DEPTH 8
// cycles after reset release before the rate strap is taken
`define WQC_ARM_CYCLES 2'h3

`endif

// file: hdl/wqc_pkg.sv
package wqc_pkg;

    // write rate taken from the strap
    typedef enum logic {RATE_SDR, RATE_DDR} wqc_rate_e;

    // port phase after reset
    typedef enum logic {PH_ARM, PH_RUN} wqc_phase_e;

    // control pins of the write port, sampled together
    typedef struct packed {
        logic wrClk;
        logic enN;
        logic selN;
        logic rate;
    } wqc_ctl_s;

endpackage

// file: hdl/wqc_fifo.sv
`timescale 1ns/10ps
`include "wqc_map.svh"

module wqc_fifo #(
    parameter int WIDTH = `WQC_DATA_W,
    parameter int DEPTH = `WQC_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstN,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [CW-1:0] cnt;
        logic [WIDTH-1:0] oData;
        logic oValid;
    } wqc_fifo_s;

    function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
        if (p == AW'(DEPTH - 1)) begin
            nextPtr = '0;
        end else begin
            nextPtr = p + 1'b1;
        end
    endfunction

    wqc_fifo_s q;
    wqc_fifo_s d;
    logic push;
    logic pop;

    assign inReady = (q.cnt != CW'(DEPTH));
    assign outValid = q.oValid;
    assign outData = q.oData;

    ////////////////////////////////////////////////////////////////////////
    // read data always leaves through the output register
    always_comb begin
        d = q;
        push = inValid && inReady;
        pop = (q.cnt != '0) && (!q.oValid || outReady);
        if (q.oValid && outReady) begin
            d.oValid = 1'b0;
        end
        if (pop) begin
            d.oData = q.mem[q.rdPtr];
            d.oValid = 1'b1;
            d.rdPtr = nextPtr(q.rdPtr);
        end
        if (push) begin
            d.mem[q.wrPtr] = inData;
            d.wrPtr = nextPtr(q.wrPtr);
        end
        if (push && !pop) begin
            d.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            d.cnt = q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    fifo_count_bound_a: assert property (@(posedge clk) disable iff (!rstN)
        q.cnt <= CW'(DEPTH))
        else $error("fifo count above depth");

    fifo_out_hold_a: assert property (@(posedge clk) disable iff (!rstN)
        (outValid && !outReady) |=> (outValid && $stable(outData)))
        else $error("stalled output word changed");

endmodule

// file: sim/wqc_host.sv
`timescale 1ns/10ps
`include "wqc_map.svh"

module wqc_host (
    // clock
    input wire logic sys_clk,
    // write pins toward the port
    output logic wrClk,
    output logic enN,
    output logic selN,
    output logic [`WQC_DATA_W-1:0] wrData
);
    initial begin
        wrClk = 1'b0;
        enN = 1'b1;
        selN = 1'b1;
        wrData = '0;
    end

    task automatic hold();
        repeat (6) @(posedge sys_clk);
        #1;
    endtask

    // strobes low qualify the rising edge
    // strobes may move between the rise and the fall
    task automatic split(input logic e0, input logic s0,
                         input logic e1, input logic s1,
                         input logic [`WQC_DATA_W-1:0] d0,
                         input logic [`WQC_DATA_W-1:0] d1);
        enN = e0;
        selN = s0;
        wrData = d0;
        hold();
        wrClk = 1'b1;
        hold();
        enN = e1;
        selN = s1;
        wrData = d1;
        hold();
        wrClk = 1'b0;
        hold();
        enN = 1'b1;
        selN = 1'b1;
        wrData = ~d1;
        hold();
    endtask

    task automatic pair(input logic e, input logic s,
                        input logic [`WQC_DATA_W-1:0] d0,
                        input logic [`WQC_DATA_W-1:0] d1);
        split(e, s, e, s, d0, d1);
    endtask
endmodule

// file: sim/tb.sv
`timescale 1ns/10ps
`include "wqc_map.svh"

module tb;
    localparam int W = `WQC_DATA_W;
    logic sys_clk, nrst, rateSel, outReady, wrClk, enN, selN;
    logic wrFull, wrOverflow, ddrMode, outValid;
    logic [W-1:0] wrData, outData;
    logic [W-1:0] got[$];
    int n_errors = 0, compares = 0, cycles = 0, ovf = 0, fullSeen = 0;

    wqc_host host (.sys_clk(sys_clk), .wrClk(wrClk), .enN(enN),
        .selN(selN), .wrData(wrData));

    wqc_write_port dut (.sys_clk(sys_clk), .nrst(nrst), .wrClk(wrClk),
        .writeEnableN(enN), .writePortSelectN(selN), .wrData(wrData),
        .writeRateSelect(rateSel), .wrFull(wrFull),
        .wrOverflow(wrOverflow), .ddrMode(ddrMode), .outValid(outValid),
        .outReady(outReady), .outData(outData));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (outValid === 1'b1 && outReady === 1'b1) got.push_back(outData);
        if (wrOverflow === 1'b1) ovf <= ovf + 1;
        if (wrFull === 1'b1) fullSeen <= 1;
        if (cycles == 4000) begin
            n_errors = n_errors + 1;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic chk1(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s exp %b got %b", nm, e, g);
        end
    endtask

    task automatic chkn(input string nm, input int e, input int g);
        compares++;
        if (g != e) begin
            n_errors++;
            $display("[FAIL] %s exp %0d got %0d", nm, e, g);
        end
    endtask

    task automatic chkq(input logic [W-1:0] e[$]);
        logic [W-1:0] g;
        chkn("count", e.size(), got.size());
        foreach (e[i]) begin
            compares++;
            g = (i < got.size()) ? got[i] : 'x;
            if (g !== e[i]) begin
                n_errors++;
                $display("[FAIL] word %0d exp %h got %h", i, e[i], g);
            end
        end
    endtask

    task automatic tally_and_finish();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic do_reset(input logic r);
        nrst = 1'b0;
        rateSel = r;
        repeat (20) @(posedge sys_clk);
        #1;
        chk1("rstValid", 1'b0, outValid);
        chk1("rstDdr", 1'b0, ddrMode);
        nrst = 1'b1;
        repeat (12) @(posedge sys_clk);
        #1;
        chk1("ddrMode", r, ddrMode);
        got.delete();
    endtask

    ////////////////////////////////////////////////////////////////////
    task automatic t_sdr();
        do_reset(1'b0);
        outReady = 1'b1;
        host.pair(1'b0, 1'b0, 40'ha1, 40'hb1);
        host.pair(1'b1, 1'b0, 40'ha2, 40'hb2);
        host.pair(1'b0, 1'b1, 40'ha3, 40'hb3);
        host.pair(1'b1, 1'b1, 40'ha4, 40'hb4);
        host.pair(1'b0, 1'b0, 40'ha5, 40'hb5);
        host.split(1'b1, 1'b1, 1'b0, 1'b0, 40'ha7, 40'hb7);
        host.split(1'b0, 1'b0, 1'b1, 1'b1, 40'ha6, 40'hb6);
        repeat (30) @(posedge sys_clk);
        #1;
        chkq('{40'ha1, 40'ha5, 40'ha6});
    endtask

    task automatic t_ddr();
        do_reset(1'b1);
        outReady = 1'b1;
        host.pair(1'b0, 1'b0, 40'hc1, 40'hd1);
        host.pair(1'b1, 1'b0, 40'hc2, 40'hd2);
        host.pair(1'b0, 1'b0, 40'hc3, 40'hd3);
        host.split(1'b1, 1'b1, 1'b0, 1'b0, 40'he1, 40'hf1);
        host.split(1'b0, 1'b0, 1'b1, 1'b1, 40'he2, 40'hf2);
        repeat (30) @(posedge sys_clk);
        #1;
        chkq('{40'hc1, 40'hd1, 40'hc3, 40'hd3, 40'he2, 40'hf2});
    endtask

    task automatic t_ovf();
        logic [W-1:0] e[$];
        outReady = 1'b0;
        got.delete();
        for (int i = 0; i < 6; i++) begin
            host.pair(1'b0, 1'b0, W'(2 * i), W'(2 * i + 1));
        end
        for (int i = 0; i < 10; i++) e.push_back(W'(i));
        repeat (20) @(posedge sys_clk);
        #1;
        chkn("full", 1, fullSeen);
        chkn("overflow", 2, ovf);
        outReady = 1'b1;
        repeat (40) @(posedge sys_clk);
        #1;
        chkq(e);
        chk1("fullAfter", 1'b0, wrFull);
    endtask

    initial begin
        outReady = 1'b0;
        // strap only moves while reset is held
        t_sdr();
        t_ddr();
        t_ovf();
        tally_and_finish();
    end
endmodule
